// file: core/led_row_fault_manager.sv
/*
  Fault manager of a six-channel LED string driver: per-channel
  disable, boost switch pause, latched shutdown, open-drain fault
  output, Avalon-MM register slave and a masked interrupt.
  Assumes comparator and protection inputs are levels from the
  analogue side; the mode input is a static strap.
*/
`timescale 1ns/10ps
// Function
// RULE1: Switch over-current pauses the boost switch and leaves fault released.
// RULE2: Over-voltage or over-temperature pulls fault low and latches the device off.
// RULE3: One channel above short threshold is disabled and fault pulled low.
// RULE4: Mode low, shorts on several channels latch off with fault low.
// RULE5: Mode high, shorts on several channels disable them, rest keep running.
// RULE6: A single open channel is disabled and fault pulled low.
// RULE7: Several open channels pull fault low; latch off when mode low.
// RULE8: Open plus short on other channels: fault low, latch or disable by mode.
// RULE9: A short break in a channel counts as open and disables it.
// RULE10: A reconnected channel reads above threshold and is flagged shorted.
// RULE11: Short detection keeps watching channels disabled as open.
// RULE12: Host toggles enable after a fault and rechecks the fault pin.
// RULE13: Latched off holds until enable toggles or power-on reset.
// RULE14: Fault output is open-drain, active low.
// RULE15: Mode is a static strap choosing the handling policy.
// RULE16: Every channel is compared continuously with the short threshold.
// RULE17: Enable, mode and comparator inputs are synchronised before use.
module led_row_fault_manager
  import fault_mgr_pkg::*;
#(
  parameter int N_ROWS = ROWS
) (
  input wire logic CLK_IN,
  input wire logic NRST_IN,
  input wire logic EN_IN,
  input wire logic MODE_IN,
  input wire logic OVERCURRENT_IN,
  input wire logic OVERVOLT_IN,
  input wire logic THERMAL_IN,
  input wire logic [N_ROWS-1:0] SHORT_CMP_IN,
  input wire logic [N_ROWS-1:0] OPEN_DET_IN,
  input wire logic [AW-1:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [DW-1:0] AVS_WRITEDATA,
  output logic [DW-1:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  output logic FAULT_N_OUT,
  output logic FAULT_OE_OUT,
  output logic SWITCH_OFF_OUT,
  output logic DEVICE_OFF_OUT,
  output logic [N_ROWS-1:0] ROW_DISABLE_OUT,
  output logic IRQ_OUT
);

  // Channel bits must stay below the status fields
  if (N_ROWS < 2 || N_ROWS > STB_LATCHED) begin : g_bad_rows
    $error("N_ROWS must lie between 2 and 8");
  end

  typedef struct packed {
    dev_state_e st;
    logic [N_ROWS-1:0] short_seen;
    logic [N_ROWS-1:0] open_seen;
    logic fault;
    logic sw_off;
    logic ocp_prev;
    logic [EV_W-1:0] irq_stat;
    logic [EV_W-1:0] irq_mask;
    logic ack;
    logic [DW-1:0] rdata;
  } core_s;

  core_s q;
  core_s d;

  avs_req_s req;
  prot_s prot;
  logic en_s;
  logic mode_s;
  logic [N_ROWS-1:0] short_s;
  logic [N_ROWS-1:0] open_raw_s;
  logic [N_ROWS-1:0] open_s;
  logic [N_ROWS-1:0] dis_q;
  logic [N_ROWS-1:0] short_nx;
  logic [N_ROWS-1:0] open_nx;
  logic [N_ROWS-1:0] dis_nx;
  logic multi_nx;
  logic [EV_W-1:0] ev;
  logic [DW-1:0] rd_mux;

  // True when the request hits the given register
  function automatic logic hit(input logic [AW-1:0] a, input logic [AW-1:0] ofs);
    return a == ofs;
  endfunction

  // Bus request bundle
  assign req = '{read: AVS_READ, write: AVS_WRITE, address: AVS_ADDRESS, wdata: AVS_WRITEDATA};

  // RULE17: synchronise control levels
  sync_2ff #(
    .W(2 + EV_W)
  ) u_sync_ctl (
    .clk_in(CLK_IN),
    .nrst_in(NRST_IN),
    .d_in({EN_IN, MODE_IN, OVERCURRENT_IN, OVERVOLT_IN, THERMAL_IN}),
    .q_out({en_s, mode_s, prot})
  );

  // RULE16: sample both comparator banks every clock
  sync_2ff #(
    .W(2 * N_ROWS)
  ) u_sync_row (
    .clk_in(CLK_IN),
    .nrst_in(NRST_IN),
    .d_in({SHORT_CMP_IN, OPEN_DET_IN}),
    .q_out({short_s, open_raw_s})
  );

  assign dis_q = q.short_seen | q.open_seen;

  // RULE9: an open reading on a live channel is an open fault
  assign open_s = open_raw_s & ~dis_q;

  // RULE11: short detection stays active on disabled channels
  assign short_nx = q.short_seen | short_s;
  assign open_nx = q.open_seen | open_s;

  // RULE15: strap level selects the policy
  row_fault_classify #(
    .N(N_ROWS)
  ) u_classify (
    .short_in(short_nx),
    .open_in(open_nx),
    .mode_high_in(mode_s),
    .disable_out(dis_nx),
    .multi_out(multi_nx)
  );

  // Register read multiplexer; unmapped addresses read zero
  always_comb begin
    rd_mux = '0;
    if (hit(req.address, OFS_STATE)) begin
      rd_mux[N_ROWS-1:0] = dis_q;
      rd_mux[STB_LATCHED] = (q.st == ST_LATCH);
      rd_mux[STB_FAULT] = q.fault;
      rd_mux[STB_MODE] = mode_s;
      rd_mux[STB_ENABLE] = en_s;
      rd_mux[STB_SWOFF] = q.sw_off;
    end else if (hit(req.address, OFS_IRQ_STAT)) begin
      rd_mux[EV_W-1:0] = q.irq_stat;
    end else if (hit(req.address, OFS_IRQ_MASK)) begin
      rd_mux[EV_W-1:0] = q.irq_mask;
    end
  end

  // Next-state logic: device state, fault sets, events, bus
  always_comb begin
    d = q;
    ev = '0;
    d.ack = 1'b0;
    unique case (q.st)
      ST_OFF: begin
        // RULE13: enable low clears every latched fault
        d.short_seen = '0;
        d.open_seen = '0;
        if (en_s) begin
          d.st = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!en_s) begin
          d.st = ST_OFF;
        // RULE2: over-voltage or over-temperature latches off
        end else if (prot.overvolt || prot.thermal) begin
          d.st = ST_LATCH;
        end else begin
          // RULE10: a channel read high after reconnect is shorted
          d.short_seen = short_nx;
          // RULE6: a single open channel is disabled
          d.open_seen = open_nx;
          // RULE4: several faulty channels latch off with mode low
          // RULE7: same for several open channels
          // RULE8: same for open plus short on other channels
          if (multi_nx) begin
            d.st = ST_LATCH;
          end
        end
      end
      ST_LATCH: begin
        // RULE13: only enable going low leaves the latch
        if (!en_s) begin
          d.st = ST_OFF;
        end
      end
    endcase
    // RULE3: any disabled channel or latch pulls fault low
    // RULE5: mode high keeps running with faulty channels off
    d.fault = (d.st == ST_LATCH) || (d.st == ST_RUN && (|(d.short_seen | d.open_seen)));
    // RULE1: over-current pauses the switch, fault untouched
    d.sw_off = prot.overcurrent || (d.st != ST_RUN);
    d.ocp_prev = prot.overcurrent;
    // Interrupt events
    ev[EV_ROW] = |((d.short_seen | d.open_seen) & ~dis_q);
    ev[EV_LATCH] = (d.st == ST_LATCH) && (q.st != ST_LATCH);
    ev[EV_OCP] = prot.overcurrent && !q.ocp_prev;
    // Read clears what was captured; new events win
    d.irq_stat = q.irq_stat | ev;
    if (q.ack && req.read && hit(req.address, OFS_IRQ_STAT)) begin
      d.irq_stat = (q.irq_stat & ~q.rdata[EV_W-1:0]) | ev;
    end
    // Bus: capture on first edge, complete on second
    if ((req.read || req.write) && !q.ack) begin
      d.ack = 1'b1;
      d.rdata = req.read ? rd_mux : '0;
    end
    if (q.ack && req.write && hit(req.address, OFS_IRQ_MASK)) begin
      d.irq_mask = req.wdata[EV_W-1:0];
    end
  end

  // State register
  always_ff @(posedge CLK_IN) begin
    if (!NRST_IN) begin
      q.st <= ST_OFF;
      q.short_seen <= '0;
      q.open_seen <= '0;
      q.fault <= 1'b0;
      q.sw_off <= 1'b1;
      q.ocp_prev <= 1'b0;
      q.irq_stat <= '0;
      q.irq_mask <= MASK_RST;
      q.ack <= 1'b0;
      q.rdata <= '0;
    end else begin
      q <= d;
    end
  end

  // Outputs
  assign AVS_WAITREQUEST = (req.read || req.write) && !q.ack;
  assign AVS_READDATA = q.rdata;
  // RULE14: open-drain, pull low only while a fault stands
  assign FAULT_N_OUT = 1'b0;
  assign FAULT_OE_OUT = q.fault;
  assign SWITCH_OFF_OUT = q.sw_off;
  assign DEVICE_OFF_OUT = (q.st != ST_RUN);
  assign ROW_DISABLE_OUT = dis_q;
  assign IRQ_OUT = |(q.irq_stat & q.irq_mask);

  // Checks
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (!NRST_IN);

  chk_ocp_switch: assert property (prot.overcurrent |=> SWITCH_OFF_OUT) // RULE1
    else $error("switch not paused on over-current");
  chk_ocp_quiet: assert property ( // RULE1
    (q.st == ST_RUN && en_s && prot == 3'h4 && dis_q == '0 && short_s == '0 && open_s == '0)
    |=> !FAULT_OE_OUT)
    else $error("fault pulled by over-current alone");
  chk_prot_latch: assert property ( // RULE2
    (q.st == ST_RUN && en_s && (prot.overvolt || prot.thermal))
    |=> (q.st == ST_LATCH && FAULT_OE_OUT && DEVICE_OFF_OUT))
    else $error("protection did not latch off");
  chk_single_short: assert property ( // RULE3
    (q.st == ST_RUN && en_s && !prot.overvolt && !prot.thermal && dis_q == '0
     && $onehot(short_s) && open_s == '0)
    |=> (ROW_DISABLE_OUT == $past(short_s) && FAULT_OE_OUT && q.st == ST_RUN))
    else $error("single short not handled");
  chk_multi_latch: assert property ( // RULE4
    (q.st == ST_RUN && en_s && !prot.overvolt && !prot.thermal && multi_nx)
    |=> q.st == ST_LATCH ##1 FAULT_OE_OUT [*2])
    else $error("multi fault did not latch");
  chk_multi_run: assert property ( // RULE5
    (q.st == ST_RUN && en_s && mode_s && !prot.overvolt && !prot.thermal)
    |=> q.st == ST_RUN)
    else $error("mode high left run state");
  chk_open_off: assert property ( // RULE6
    (q.st == ST_RUN && en_s && !prot.overvolt && !prot.thermal && open_s != '0)
    |=> ((ROW_DISABLE_OUT & $past(open_s)) == $past(open_s) && FAULT_OE_OUT))
    else $error("open channel not disabled");
  chk_short_watch: assert property ( // RULE11
    (q.st == ST_RUN && en_s && !prot.overvolt && !prot.thermal && (short_s & q.open_seen) != '0)
    |=> (q.short_seen & $past(short_s)) == $past(short_s))
    else $error("short missed on disabled channel");
  chk_latch_hold: assert property ((q.st == ST_LATCH && en_s) |=> q.st == ST_LATCH) // RULE13
    else $error("latch released without enable toggle");
  chk_en_sync: assert property ((!EN_IN) [*3] |=> (q.st == ST_OFF && !FAULT_OE_OUT)) // RULE17
    else $error("enable low not seen after sync delay");
  chk_bus_answer: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("bus answer later than one wait cycle");

  cov_latch: cover property (q.st == ST_RUN ##1 q.st == ST_LATCH);
  cov_multi_hi: cover property (q.st == ST_RUN && mode_s && $countones(dis_q) > 1);
  cov_irq: cover property ($rose(IRQ_OUT));
  cov_reconnect: cover property (q.open_seen != '0 ##1 (q.short_seen & q.open_seen) != '0);

endmodule

// file: include/fault_mgr_pkg.sv
/*
  Shared constants and types for the LED string fault manager:
  register map, field positions, event bits, state codes, carriers.
  Assumes a 32-bit Avalon-MM slave with byte addresses.
*/
package fault_mgr_pkg;

  // Channel count and bus widths
  localparam int ROWS = 6;
  localparam int AW = 4;
  localparam int DW = 32;

  // Register byte offsets
  localparam logic [AW-1:0] OFS_STATE = 4'h0;
  localparam logic [AW-1:0] OFS_IRQ_STAT = 4'h4;
  localparam logic [AW-1:0] OFS_IRQ_MASK = 4'h8;

  // State register field positions (channel bits sit at 0 upward)
  localparam int STB_LATCHED = 8;
  localparam int STB_FAULT = 9;
  localparam int STB_MODE = 10;
  localparam int STB_ENABLE = 11;
  localparam int STB_SWOFF = 12;

  // Event bits, shared by status and mask registers
  localparam int EV_W = 3;
  localparam int EV_ROW = 0;
  localparam int EV_LATCH = 1;
  localparam int EV_OCP = 2;
  localparam logic [EV_W-1:0] MASK_RST = 3'h0;

  // Comparator trip level of the shorted-LED detector, in millivolts
  localparam int SHORT_THRESH_MV = 8200;

  // Device state, one-hot
  typedef enum logic [2:0] {
    ST_OFF = 3'h1,
    ST_RUN = 3'h2,
    ST_LATCH = 3'h4
  } dev_state_e;

  // Bus request carrier
  typedef struct packed {
    logic read;
    logic write;
    logic [AW-1:0] address;
    logic [DW-1:0] wdata;
  } avs_req_s;

  // Boost-section protection indications
  typedef struct packed {
    logic overcurrent;
    logic overvolt;
    logic thermal;
  } prot_s;

endpackage

// file: core/sync_2ff.sv
/*
  Two-flop level synchroniser for a bus of independent bits.
  Assumes each bit is a slow level; no word coherence is implied.
*/
`timescale 1ns/10ps
module sync_2ff #(
  parameter int W = 1
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_s;

  sync_s q;
  sync_s d;

  // Shift chain; first stage feeds only the second
  always_comb begin
    d = q;
    d.s1 = d_in;
    d.s2 = q.s1;
  end

  // Synchronous low-active reset
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign q_out = q.s2;

endmodule

// file: core/row_fault_classify.sv
/*
  Combinational classifier of channel faults: which channels are
  disabled and whether the fault pattern forces a latched shutdown.
  Assumes the fault sets are already accumulated by the caller.
*/
`timescale 1ns/10ps
module row_fault_classify #(
  parameter int N = 6
) (
  input wire logic [N-1:0] short_in,
  input wire logic [N-1:0] open_in,
  input wire logic mode_high_in,
  output logic [N-1:0] disable_out,
  output logic multi_out
);

  // Number of faulty channels, each counted once
  function automatic int unsigned count_ones(input logic [N-1:0] v);
    int unsigned n;
    n = 0;
    for (int i = 0; i < N; i++) begin
      n = n + v[i];
    end
    return n;
  endfunction

  // A channel that reopened and then reads high counts once
  assign disable_out = short_in | open_in;

  // More than one faulty channel latches off only with mode low
  assign multi_out = !mode_high_in && (count_ones(disable_out) > 1);

endmodule

// file: testbench/fault_host.sv
/*
  Host-side model: watches the open-drain fault pin and drives enable.
  Assumes the bench asks for an enable toggle with a one-cycle pulse.
*/
`timescale 1ns/10ps
module fault_host (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic toggle_in,
  input wire logic fault_n_in,
  input wire logic fault_oe_in,
  output logic en_out,
  output logic busy_out,
  output logic fault_seen_out
);
  logic [2:0] cnt_q;
  logic pin;
  assign pin = fault_oe_in ? fault_n_in : 1'b1;
  assign fault_seen_out = (pin == 1'b0);
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      cnt_q <= 3'h0;
    end else if (toggle_in && cnt_q == 3'h0) begin
      cnt_q <= 3'h4; // Enable low four cycles
    end else if (cnt_q != 3'h0) begin
      cnt_q <= cnt_q - 3'h1;
    end
  end
  assign en_out = (cnt_q == 3'h0);
  assign busy_out = (cnt_q != 3'h0);
endmodule

// file: testbench/led_row_fault_manager_bench.sv
/*
  Self-checking bench of the LED string fault manager.
  Assumes the fault manager latencies of three edges and one wait cycle.
*/
`timescale 1ns/10ps
module led_row_fault_manager_bench;
  import fault_mgr_pkg::*;
  logic clk = 1'b0, nrst = 1'b0, mode = 1'b0, oc = 1'b0, ov = 1'b0, th = 1'b0, tgl = 1'b0;
  logic rd = 1'b0, wr = 1'b0, en, busy, seen, fault_n, fault_oe, sw_off, dev_off, irq, wait_rq;
  logic [5:0] sh = 6'h00, op = 6'h00, dis;
  logic [AW-1:0] adr = 4'h0;
  logic [DW-1:0] wd = 32'h0, rdat, got;
  int num_errors = 0, samples_checked = 0, cyc = 0;
  led_row_fault_manager led_row_fault_manager_inst (.CLK_IN(clk), .NRST_IN(nrst), .EN_IN(en),
    .MODE_IN(mode), .OVERCURRENT_IN(oc), .OVERVOLT_IN(ov), .THERMAL_IN(th), .SHORT_CMP_IN(sh),
    .OPEN_DET_IN(op), .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wd),
    .AVS_READDATA(rdat), .AVS_WAITREQUEST(wait_rq), .FAULT_N_OUT(fault_n), .FAULT_OE_OUT(fault_oe),
    .SWITCH_OFF_OUT(sw_off), .DEVICE_OFF_OUT(dev_off), .ROW_DISABLE_OUT(dis), .IRQ_OUT(irq));
  fault_host fault_host_inst (.clk_in(clk), .nrst_in(nrst), .toggle_in(tgl), .fault_n_in(fault_n),
    .fault_oe_in(fault_oe), .en_out(en), .busy_out(busy), .fault_seen_out(seen));
  // Clock of 50 ns period
  initial begin
    forever #25 clk = ~clk;
  end
  // Hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors = num_errors + 1;
      conclude();
    end
  end
  task automatic conclude();
    $display("errors %0d, comparisons %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen_v);
    samples_checked = samples_checked + 1;
    if (seen_v !== exp) begin
      num_errors = num_errors + 1;
      $display("mismatch %s expected %h seen %h", what, exp, seen_v);
    end
  endtask
  // One Avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [AW-1:0] a, input logic [DW-1:0] d);
    rd <= ~w;
    wr <= w;
    adr <= a;
    wd <= d;
    // Wait for the answer; only the hang guard ends a stuck wait
    do begin
      @(posedge clk);
    end while (wait_rq !== 1'b0);
    got = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic toggle_en();
    int n;
    tgl <= 1'b1;
    @(posedge clk);
    tgl <= 1'b0;
    @(posedge clk);
    for (n = 0; n < 20 && busy === 1'b1; n++) @(posedge clk);
    repeat (6) @(posedge clk);
  endtask
  // Apply one fault pattern, compare outputs, then clear by enable toggle
  task automatic run_case(input logic m, input logic [5:0] s, input logic [5:0] o, input logic [2:0] p,
                          input logic [5:0] ed, input logic ef, input logic eo, input logic es);
    mode <= m;
    repeat (6) @(posedge clk);
    sh <= s;
    op <= o;
    {oc, ov, th} <= p;
    repeat (6) @(posedge clk);
    chk("fault", {31'h0, ef}, {31'h0, seen});
    chk("device off", {31'h0, eo}, {31'h0, dev_off});
    chk("switch off", {31'h0, es}, {31'h0, sw_off});
    chk("fault data", 32'h0, {31'h0, fault_n});
    if (eo === 1'b0) chk("disables", {26'h0, ed}, {26'h0, dis});
    sh <= 6'h00;
    op <= 6'h00;
    {oc, ov, th} <= 3'h0;
    repeat (6) @(posedge clk);
    chk("held off", {31'h0, eo}, {31'h0, dev_off});
    toggle_en();
    chk("cleared", 32'h0, {25'h0, dis, seen});
  endtask
  // Main sequence
  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    repeat (6) @(posedge clk);
    bus(1'b0, OFS_IRQ_MASK, 32'h0);
    chk("mask reset", 32'h0, got);
    bus(1'b0, 4'hC, 32'h0);
    chk("unmapped", 32'h0, got);
    bus(1'b0, OFS_IRQ_STAT, 32'h0);
    run_case(1'b0, 6'h00, 6'h00, 3'h4, 6'h00, 1'b0, 1'b0, 1'b1);
    run_case(1'b1, 6'h00, 6'h00, 3'h4, 6'h00, 1'b0, 1'b0, 1'b1);
    run_case(1'b0, 6'h00, 6'h00, 3'h2, 6'h00, 1'b1, 1'b1, 1'b1);
    run_case(1'b1, 6'h00, 6'h00, 3'h1, 6'h00, 1'b1, 1'b1, 1'b1);
    run_case(1'b0, 6'h04, 6'h00, 3'h0, 6'h04, 1'b1, 1'b0, 1'b0);
    run_case(1'b1, 6'h20, 6'h00, 3'h0, 6'h20, 1'b1, 1'b0, 1'b0);
    run_case(1'b0, 6'h21, 6'h00, 3'h0, 6'h00, 1'b1, 1'b1, 1'b1);
    run_case(1'b1, 6'h21, 6'h00, 3'h0, 6'h21, 1'b1, 1'b0, 1'b0);
    run_case(1'b0, 6'h00, 6'h08, 3'h0, 6'h08, 1'b1, 1'b0, 1'b0);
    run_case(1'b1, 6'h00, 6'h01, 3'h0, 6'h01, 1'b1, 1'b0, 1'b0);
    run_case(1'b0, 6'h00, 6'h06, 3'h0, 6'h00, 1'b1, 1'b1, 1'b1);
    run_case(1'b1, 6'h00, 6'h06, 3'h0, 6'h06, 1'b1, 1'b0, 1'b0);
    run_case(1'b0, 6'h10, 6'h02, 3'h0, 6'h00, 1'b1, 1'b1, 1'b1);
    run_case(1'b1, 6'h10, 6'h02, 3'h0, 6'h12, 1'b1, 1'b0, 1'b0);
    // Channel broken, then reconnected and seen as shorted
    mode <= 1'b0;
    op <= 6'h01;
    repeat (6) @(posedge clk);
    op <= 6'h00;
    sh <= 6'h01;
    repeat (6) @(posedge clk);
    chk("reconnect off", 32'h0, {31'h0, dev_off});
    bus(1'b0, OFS_STATE, 32'h0);
    chk("state", 32'h0A01, got);
    bus(1'b1, OFS_STATE, 32'h0);
    bus(1'b0, OFS_STATE, 32'h0);
    chk("state read-only", 32'h0A01, got);
    sh <= 6'h00;
    toggle_en();
    // Interrupt: masked, unmasked, cleared by read
    bus(1'b0, OFS_IRQ_STAT, 32'h0);
    bus(1'b1, OFS_IRQ_MASK, 32'h0);
    oc <= 1'b1;
    repeat (6) @(posedge clk);
    oc <= 1'b0;
    chk("irq masked", 32'h0, {31'h0, irq});
    bus(1'b1, OFS_IRQ_MASK, 32'h4);
    chk("irq raised", 32'h1, {31'h0, irq});
    bus(1'b0, OFS_IRQ_STAT, 32'h0);
    chk("irq status", 32'h4, got);
    chk("irq cleared", 32'h0, {31'h0, irq});
    conclude();
  end
endmodule
